// file: event_status.v
// sticky event status with read-to-clear, mask and one level interrupt
// assumes set pulses and the read strobe are synchronous to clk
`timescale 1ns/1ps
module event_status #(
    parameter N = 2
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // events and software access
    input wire [N-1:0] set_pulse,
    input wire rd_clr,
    input wire mask_we,
    input wire [N-1:0] mask_wdata,
    // state
    output reg [N-1:0] status_r,
    output reg [N-1:0] mask_r,
    output reg irq_r
);
    reg [N-1:0] status_nxt;
    reg [N-1:0] mask_nxt;

    // a set in the clearing cycle survives
    always @* begin
        status_nxt = (status_r & ~{N{rd_clr}}) | set_pulse;
        mask_nxt = mask_we ? mask_wdata : mask_r;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            status_r <= {N{1'b0}};
            mask_r <= {N{1'b0}};
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            irq_r <= |(status_nxt & mask_nxt);
        end
    end
endmodule

// file: window_channel.v
// one channel of the digital window comparator with qualifying counter
// assumes a sample arrives with a one-cycle valid strobe
`timescale 1ns/1ps
module window_channel #(
    parameter RW = 12
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // conversion samples
    input wire sample_valid,
    input wire [RW-1:0] sample,
    // limit settings
    input wire [7:0] high_byte,
    input wire [3:0] high_nibble,
    input wire [7:0] low_byte,
    input wire [3:0] low_nibble,
    input wire [3:0] hyst,
    input wire [3:0] qualify,
    // results
    output reg alert_r,
    output reg high_evt_r,
    output reg low_evt_r
);
    wire [11:0] high_lim = {high_byte, high_nibble};
    wire [11:0] low_lim = {low_byte, low_nibble};
    wire [11:0] hyst_w = {5'h00, hyst, 3'h0};
    wire [12:0] low_sum = {1'b0, low_lim} + {1'b0, hyst_w};
    wire [11:0] high_rel = (high_lim > hyst_w) ? (high_lim - hyst_w) : 12'h000;
    wire [11:0] low_rel = low_sum[12] ? 12'hFFF : low_sum[11:0];
    wire [11:0] s12 = sample[RW-1:RW-12];

    reg above_r;
    reg below_r;
    reg [4:0] run_r;
    reg above_nxt;
    reg below_nxt;
    reg [4:0] run_nxt;
    reg qual_now;

    always @* begin
        // strict compares; hysteresis holds a side until it is left by the margin
        above_nxt = above_r ? (s12 > high_rel) : (s12 > high_lim);
        below_nxt = below_r ? (s12 < low_rel) : (s12 < low_lim);
        run_nxt = run_r;
        qual_now = 1'b0;
        if (above_nxt || below_nxt) begin
            if (run_r <= {1'b0, qualify})
                run_nxt = run_r + 5'h01;
            qual_now = (run_nxt == ({1'b0, qualify} + 5'h01));
        end else begin
            run_nxt = 5'h00;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            above_r <= 1'b0;
            below_r <= 1'b0;
            run_r <= 5'h00;
            alert_r <= 1'b0;
            high_evt_r <= 1'b0;
            low_evt_r <= 1'b0;
        end else begin
            high_evt_r <= 1'b0;
            low_evt_r <= 1'b0;
            if (sample_valid) begin
                above_r <= above_nxt;
                below_r <= below_nxt;
                run_r <= run_nxt;
                alert_r <= qual_now;
                if (qual_now && !alert_r) begin
                    high_evt_r <= above_nxt;
                    low_evt_r <= below_nxt;
                end
            end
        end
    end
endmodule

// file: window_limits.v
// limit register bank for channels 1 to 3 behind an AXI4-Lite slave,
// channel 2 window comparator and alert interrupt
// assumes a single clock; conversion results synchronous to aclk
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "window_limits_map.vh"
module window_limits #(
    parameter RW = 12
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write address
    input wire [7:0] awaddr,
    input wire [2:0] awprot,
    input wire awvalid,
    output wire awready,
    // write data
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    // write response
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    // read address
    input wire [7:0] araddr,
    input wire [2:0] arprot,
    input wire arvalid,
    output wire arready,
    // read data
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    // conversion results
    input wire conv_valid,
    input wire [RW-1:0] conv_result,
    // limits handed to the neighbouring channel logic
    output wire [7:0] ch1_low_limit_byte,
    output wire [7:0] ch3_high_limit_byte,
    output wire [3:0] ch3_high_limit_nibble,
    output wire [3:0] ch3_hyst_field,
    // channel 2 alert and interrupt
    output wire ch2_alert,
    output wire irq
);
    // bus state
    reg awready_r;
    reg wready_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg arready_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;
    reg aw_hold_r;
    reg [7:0] awaddr_r;
    reg w_hold_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;

    // limit registers
    reg [7:0] ch1_low_upper_r;
    reg [7:0] ch2_hyst_r;
    reg [7:0] ch2_high_upper_r;
    reg [7:0] ch2_count_r;
    reg [7:0] ch2_low_upper_r;
    reg [7:0] ch3_hyst_r;
    reg [7:0] ch3_high_upper_r;

    // next values
    reg aw_hold_nxt;
    reg w_hold_nxt;
    reg bvalid_nxt;
    reg rvalid_nxt;
    reg [31:0] rd_mux;
    reg rd_hit;
    reg wr_hit;

    wire aw_take = awvalid & awready_r;
    wire w_take = wvalid & wready_r;
    wire ar_take = arvalid & arready_r;
    wire aw_have = aw_hold_r | aw_take;
    wire w_have = w_hold_r | w_take;
    wire do_write = aw_have & w_have & ~bvalid_r;
    wire [7:0] wr_addr = aw_hold_r ? awaddr_r : awaddr;
    wire [31:0] wr_data = w_hold_r ? wdata_r : wdata;
    wire [3:0] wr_strb = w_hold_r ? wstrb_r : wstrb;
    wire [5:0] wr_idx = wr_addr[7:2];
    wire [5:0] rd_idx = araddr[7:2];
    wire wr_lane0 = do_write & wr_strb[0];
    wire [7:0] wr_byte = wr_data[7:0];

    // interrupt and comparator wiring
    wire [`ST_WIDTH-1:0] irq_status;
    wire [`ST_WIDTH-1:0] irq_mask;
    wire irq_w;
    wire alert_w;
    wire high_evt;
    wire low_evt;
    wire status_rd = ar_take & (rd_idx == `IDX_IRQ_STATUS);
    wire mask_we = wr_lane0 & (wr_idx == `IDX_IRQ_MASK);

    // index compare: byte address is four times the index
    function is_idx;
        input [5:0] idx;
        input [7:0] reg_idx;
        begin
            is_idx = ({2'h0, idx} == reg_idx);
        end
    endfunction

    // handshake next state
    always @* begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
        end else begin
            if (aw_take)
                aw_hold_nxt = 1'b1;
            if (w_take)
                w_hold_nxt = 1'b1;
        end
        bvalid_nxt = do_write | (bvalid_r & ~bready);
        rvalid_nxt = ar_take | (rvalid_r & ~rready);
    end

    // address decode for writes
    always @* begin
        wr_hit = is_idx(wr_idx, `IDX_CH1_LOW_UPPER) |
                 is_idx(wr_idx, `IDX_CH2_HYST) |
                 is_idx(wr_idx, `IDX_CH2_HIGH_UPPER) |
                 is_idx(wr_idx, `IDX_CH2_COUNT) |
                 is_idx(wr_idx, `IDX_CH2_LOW_UPPER) |
                 is_idx(wr_idx, `IDX_CH3_HYST) |
                 is_idx(wr_idx, `IDX_CH3_HIGH_UPPER) |
                 is_idx(wr_idx, `IDX_IRQ_STATUS) |
                 is_idx(wr_idx, `IDX_IRQ_MASK);
    end

    // read mux; limit registers read back unchanged
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case ({2'h0, rd_idx})
            `IDX_CH1_LOW_UPPER: rd_mux[7:0] = ch1_low_upper_r;
            `IDX_CH2_HYST: rd_mux[7:0] = ch2_hyst_r;
            `IDX_CH2_HIGH_UPPER: rd_mux[7:0] = ch2_high_upper_r;
            `IDX_CH2_COUNT: rd_mux[7:0] = ch2_count_r;
            `IDX_CH2_LOW_UPPER: rd_mux[7:0] = ch2_low_upper_r;
            `IDX_CH3_HYST: rd_mux[7:0] = ch3_hyst_r;
            `IDX_CH3_HIGH_UPPER: rd_mux[7:0] = ch3_high_upper_r;
            `IDX_IRQ_STATUS: rd_mux[`ST_WIDTH-1:0] = irq_status;
            `IDX_IRQ_MASK: rd_mux[`ST_WIDTH-1:0] = irq_mask;
            default: rd_hit = 1'b0;
        endcase
    end

    // bus channel registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `RESP_OKAY;
            aw_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            w_hold_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
            wready_r <= ~w_hold_nxt & ~bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (aw_take)
                awaddr_r <= awaddr;
            if (w_take) begin
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (do_write)
                bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (ar_take) begin
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // limit registers; lane 0 carries the byte
    always @(posedge aclk) begin
        if (!aresetn) begin
            ch1_low_upper_r <= `RST_LOW_UPPER;
            ch2_hyst_r <= `RST_HYST;
            ch2_high_upper_r <= `RST_HIGH_UPPER;
            ch2_count_r <= `RST_COUNT;
            ch2_low_upper_r <= `RST_LOW_UPPER;
            ch3_hyst_r <= `RST_HYST;
            ch3_high_upper_r <= `RST_HIGH_UPPER;
        end else if (wr_lane0) begin
            case ({2'h0, wr_idx})
                `IDX_CH1_LOW_UPPER: ch1_low_upper_r <= wr_byte;
                `IDX_CH2_HYST: ch2_hyst_r <= wr_byte;
                `IDX_CH2_HIGH_UPPER: ch2_high_upper_r <= wr_byte;
                `IDX_CH2_COUNT: ch2_count_r <= wr_byte;
                `IDX_CH2_LOW_UPPER: ch2_low_upper_r <= wr_byte;
                `IDX_CH3_HYST: ch3_hyst_r <= wr_byte;
                `IDX_CH3_HIGH_UPPER: ch3_high_upper_r <= wr_byte;
                default: ch1_low_upper_r <= ch1_low_upper_r;
            endcase
        end
    end

    // channel 2 comparator
    window_channel #(
        .RW(RW)
    ) ch2_window (
        .clk(aclk),
        .rst_n(aresetn),
        .sample_valid(conv_valid),
        .sample(conv_result),
        .high_byte(ch2_high_upper_r),
        .high_nibble(ch2_hyst_r[`NIB_HI:`NIB_LO]),
        .low_byte(ch2_low_upper_r),
        .low_nibble(ch2_count_r[`NIB_HI:`NIB_LO]),
        .hyst(ch2_hyst_r[`FLD_HI:`FLD_LO]),
        .qualify(ch2_count_r[`FLD_HI:`FLD_LO]),
        .alert_r(alert_w),
        .high_evt_r(high_evt),
        .low_evt_r(low_evt)
    );

    // sticky status, cleared by reading it
    event_status #(
        .N(`ST_WIDTH)
    ) alert_irq (
        .clk(aclk),
        .rst_n(aresetn),
        .set_pulse({low_evt, high_evt}),
        .rd_clr(status_rd),
        .mask_we(mask_we),
        .mask_wdata(wr_byte[`ST_WIDTH-1:0]),
        .status_r(irq_status),
        .mask_r(irq_mask),
        .irq_r(irq_w)
    );

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign ch1_low_limit_byte = ch1_low_upper_r;
    assign ch3_high_limit_byte = ch3_high_upper_r;
    assign ch3_high_limit_nibble = ch3_hyst_r[`NIB_HI:`NIB_LO];
    assign ch3_hyst_field = ch3_hyst_r[`FLD_HI:`FLD_LO];
    assign ch2_alert = alert_w;
    assign irq = irq_w;
endmodule

// file: window_limits_map.vh
// constants for the window-comparator limit bank, channels 1 to 3
// assumes byte addresses are four times the register index
`ifndef WINDOW_LIMITS_MAP_VH
`define WINDOW_LIMITS_MAP_VH

// register indices
`define IDX_CH1_LOW_UPPER 8'h27
`define IDX_CH2_HYST 8'h28
`define IDX_CH2_HIGH_UPPER 8'h29
`define IDX_CH2_COUNT 8'h2A
`define IDX_CH2_LOW_UPPER 8'h2B
`define IDX_CH3_HYST 8'h2C
`define IDX_CH3_HIGH_UPPER 8'h2D
// interrupt registers, by index
`define IDX_IRQ_STATUS 8'h30
`define IDX_IRQ_MASK 8'h31

// reset values
`define RST_HYST 8'hF0
`define RST_HIGH_UPPER 8'hFF
`define RST_COUNT 8'h00
`define RST_LOW_UPPER 8'h00
`define RST_IRQ_MASK 2'h0

// field positions
`define NIB_HI 7
`define NIB_LO 4
`define FLD_HI 3
`define FLD_LO 0

// status bits
`define ST_HIGH 0
`define ST_LOW 1
`define ST_WIDTH 2

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: window_limits_props.sv
// checker for the limit bank: bus answer timing, reset values, alert updates
// assumes it is bound onto window_limits, one clock domain
`timescale 1ns/1ps
`include "window_limits_map.vh"
module window_limits_props (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // bus handshakes
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    input wire rready,
    // limits and alert
    input wire conv_valid,
    input wire [7:0] ch1_low_limit_byte,
    input wire [7:0] ch3_high_limit_byte,
    input wire [3:0] ch3_high_limit_nibble,
    input wire [3:0] ch3_hyst_field,
    input wire ch2_alert
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire [5:0] ai = araddr[7:2];
    wire ar_map = (ai >= 6'h27 && ai <= 6'h2D) || ai == 6'h30 || ai == 6'h31;
    sequence wr_take; awvalid && awready && wvalid && wready; endsequence
    sequence b_take; bvalid && bready; endsequence
    sequence ar_take; arvalid && arready; endsequence
    sequence r_take; rvalid && rready; endsequence
    chk_write_answer: assert property (wr_take |=> bvalid)
        else $error("no write answer");
    chk_read_answer: assert property (ar_take |=> rvalid)
        else $error("no read answer");
    chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    chk_write_reopen: assert property (b_take |=> !bvalid && awready && wready)
        else $error("write not reopened");
    chk_read_reopen: assert property (r_take |=> !rvalid && arready)
        else $error("read not reopened");
    chk_unmapped_read: assert property (ar_take ##0 !ar_map |=>
        rresp == `RESP_SLVERR && rdata == 32'h0) else $error("unmapped read answer");
    chk_mapped_read: assert property (ar_take ##0 ar_map |=>
        rresp == `RESP_OKAY && rdata[31:8] == 24'h0) else $error("mapped read answer");
    chk_reset_values: assert property ($rose(aresetn) |-> ch1_low_limit_byte == 8'h00 &&
        ch3_high_limit_byte == 8'hFF && ch3_high_limit_nibble == 4'hF && ch3_hyst_field == 4'h0)
        else $error("limits not at reset values");
    chk_alert_on_sample: assert property (!conv_valid |=> $stable(ch2_alert))
        else $error("alert moved without sample");
endmodule

bind window_limits window_limits_props u_props (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .conv_valid(conv_valid),
    .ch1_low_limit_byte(ch1_low_limit_byte), .ch3_high_limit_byte(ch3_high_limit_byte),
    .ch3_high_limit_nibble(ch3_high_limit_nibble), .ch3_hyst_field(ch3_hyst_field),
    .ch2_alert(ch2_alert)
);

// file: window_limits_test.sv
// self-checking bench for the limit bank: registers, bus answers, alert, interrupt
// assumes window_limits with its checker bound alongside
`timescale 1ns/1ps
`include "window_limits_map.vh"
`define CHK(g, e) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
    err_total = err_total + 1; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module window_limits_test;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0, seed = 32'h7610;
    reg [3:0] wstrb = 4'h0;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, conv_valid = 0;
    reg [11:0] conv_result = 12'h000;
    wire awready, wready, bvalid, arready, rvalid, ch2_alert, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] ch1_low_limit_byte, ch3_high_limit_byte;
    wire [3:0] ch3_high_limit_nibble, ch3_hyst_field;
    integer err_total = 0, comparisons = 0, k, i, run = 0;
    reg [7:0] mdl [0:6];
    reg [1:0] st_m = 2'h0, mk = 2'h0;
    reg in_hi = 0, in_lo = 0, alert_m = 0;
    window_limits #(.RW(12)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .conv_valid(conv_valid), .conv_result(conv_result),
        .ch1_low_limit_byte(ch1_low_limit_byte), .ch3_high_limit_byte(ch3_high_limit_byte),
        .ch3_high_limit_nibble(ch3_high_limit_nibble), .ch3_hyst_field(ch3_hyst_field),
        .ch2_alert(ch2_alert), .irq(irq));
    always #4 aclk = ~aclk;
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task print_verdict;
        begin
            if (err_total == 0 && comparisons > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task hang;
        begin
            err_total = err_total + 1;
            print_verdict;
        end
    endtask
    task wr(input [5:0] ix, input [7:0] d, input [3:0] st);
        reg done, mp;
        begin
            done = 0;
            mp = (ix >= 6'h27 && ix <= 6'h2D) || ix == 6'h30 || ix == 6'h31;
            seed = xs(seed);
            @(posedge aclk);
            awaddr <= {ix, 2'b00};
            wdata <= {seed[31:8], d};
            wstrb <= st;
            // either channel may trail the other by one cycle
            awvalid <= !seed[1];
            wvalid <= !seed[0];
            bready <= 1;
            for (k = 0; k < 40 && !done; k = k + 1) begin
                @(posedge aclk);
                if (awvalid && awready) awvalid <= 0;
                else if (k == 0 && !awvalid) awvalid <= 1;
                if (wvalid && wready) wvalid <= 0;
                else if (k == 0 && !wvalid) wvalid <= 1;
                if (bvalid && bready) begin
                    done = 1;
                    bready <= 0;
                    `CHK(bresp, mp ? `RESP_OKAY : `RESP_SLVERR)
                end
            end
            if (!done) hang;
            if (mp && st[0] && ix <= 6'h2D) mdl[ix - 6'h27] = d;
            if (st[0] && ix == 6'h31) mk = d[1:0];
        end
    endtask
    task rd(input [5:0] ix);
        reg done;
        reg [31:0] ev;
        reg [1:0] er;
        begin
            done = 0;
            er = `RESP_OKAY;
            if (ix >= 6'h27 && ix <= 6'h2D) ev = mdl[ix - 6'h27];
            else if (ix == 6'h30) ev = st_m;
            else if (ix == 6'h31) ev = mk;
            else begin
                ev = 0;
                er = `RESP_SLVERR;
            end
            @(posedge aclk);
            araddr <= {ix, 2'b00};
            arvalid <= 1;
            rready <= 1;
            for (k = 0; k < 40 && !done; k = k + 1) begin
                @(posedge aclk);
                if (arvalid && arready) arvalid <= 0;
                if (rvalid && rready) begin
                    done = 1;
                    rready <= 0;
                    `CHK(rdata, ev)
                    `CHK(rresp, er)
                end
            end
            if (!done) hang;
            if (ix == 6'h30) st_m = 0;
        end
    endtask
    task out_chk;
        begin
            `CHK(ch1_low_limit_byte, mdl[0])
            `CHK(ch3_high_limit_byte, mdl[6])
            `CHK(ch3_high_limit_nibble, mdl[5][7:4])
            `CHK(ch3_hyst_field, mdl[5][3:0])
        end
    endtask
    task smp(input [11:0] v);
        integer hl, ll, hy;
        reg hi, lo, a;
        begin
            hl = {mdl[2], mdl[1][7:4]};
            ll = {mdl[4], mdl[3][7:4]};
            hy = mdl[1][3:0] * 8;
            hi = v > hl || (in_hi && v + hy > hl);
            lo = v < ll || (in_lo && v < ll + hy);
            in_hi = hi;
            in_lo = lo;
            run = (hi || lo) ? run + 1 : 0;
            a = run > mdl[3][3:0];
            if (a && !alert_m) st_m = st_m | (hi ? 2'b01 : 2'b10);
            alert_m = a;
            @(posedge aclk);
            conv_valid <= 1;
            conv_result <= v;
            @(posedge aclk);
            conv_valid <= 0;
            #1 `CHK(ch2_alert, alert_m)
        end
    endtask
    task irq_chk;
        begin
            @(posedge aclk);
            #1 `CHK(irq, |(st_m & mk))
        end
    endtask
    initial begin
        mdl[0] = 8'h00; mdl[1] = 8'hF0; mdl[2] = 8'hFF; mdl[3] = 8'h00;
        mdl[4] = 8'h00; mdl[5] = 8'hF0; mdl[6] = 8'hFF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // reset image, holes at 2E and 2F
        for (i = 6'h27; i <= 6'h31; i = i + 1) rd(i[5:0]);
        out_chk;
        for (i = 6'h27; i <= 6'h2D; i = i + 1) begin
            seed = xs(seed);
            wr(i[5:0], seed[7:0], 4'hF);
        end
        wr(6'h29, 8'h12, 4'h0);
        wr(6'h20, 8'h55, 4'hF);
        wr(6'h30, 8'h03, 4'hF);
        for (i = 6'h20; i <= 6'h31; i = i + 1) rd(i[5:0]);
        out_chk;
        // high side with hysteresis, count 2
        wr(6'h31, 8'h03, 4'hF);
        wr(6'h28, 8'h42, 4'hF);
        wr(6'h29, 8'h80, 4'hF);
        wr(6'h2A, 8'h82, 4'hF);
        wr(6'h2B, 8'h10, 4'hF);
        smp(12'h805); smp(12'h804); smp(12'h805); smp(12'hFFF); smp(12'h7FD);
        irq_chk;
        smp(12'h7F4);
        rd(6'h30);
        rd(6'h30);
        irq_chk;
        // low side while masked
        wr(6'h31, 8'h01, 4'hF);
        smp(12'h108); smp(12'h107); smp(12'h107); smp(12'h117);
        irq_chk;
        wr(6'h31, 8'h03, 4'hF);
        irq_chk;
        rd(6'h30);
        irq_chk;
        for (i = 0; i < 40; i = i + 1) begin
            seed = xs(seed);
            smp(seed[11:0]);
        end
        rd(6'h30);
        print_verdict;
    end
endmodule
